// *** rtl/irqmt_top.sv ***
// Purpose: Interrupt line routing, enable set/clear pairs, absolute and relative timers
// Assumes: Flag sources, macrotick counter and protocol state come from outside
// Notes: Registers answer with one wait state; unmapped reads return zero
//
// Operation
// - Status flag goes to line one when its select bit is 1, else line zero.
// - Error flag goes to line one when its select bit is 1, else line zero.
// - Error enables: write 1 at set address sets, at clear address clears.
// - Status enables: write 1 at set address sets, at clear address clears.
// - Reading set or clear address returns the same enable vector.
// - Error flag interrupts only when its enable bit is 1.
// - Status flag interrupts only when enabled; disabled flags still set.
// - Each host line gated by its own independent line-enable bit.
// - Absolute timer compares cycle set and macrotick with the shared counter.
// - Absolute timer fire: timer-zero output high one macrotick, flag set.
// - Absolute timer runs only in normal active or passive states.
// - Absolute timer mode bit: 1 continuous, 0 single-shot.
// - Seven-bit cycle code selects the cycles where the absolute timer fires.
// - Fourteen-bit macrotick offset fixes the firing point in each selected cycle.
// - Timer-zero output drops at once on leaving normal states or halt.
// - Relative timer fires after its count; timer-one output pulses, flag set.
// - Relative timer runs only in normal active or passive states.
`timescale 1ns/1ps
module irqmt_top (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [5:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic [31:0] errorFlagReg,
	input wire logic [31:0] statusFlagReg,
	input wire logic mtTick,
	input wire logic [13:0] macrotick,
	input wire logic [5:0] cycleCount,
	input wire logic pocNormal,
	output logic hostIrqLineZero,
	output logic hostIrqLineOne,
	output logic timerZeroOut,
	output logic timerOneOut,
	output logic [1:0] timerFlags
);
	logic waitReq_q;
	logic [31:0] rdData_q;
	logic [31:0] errLineSel_q;
	logic [31:0] statLineSel_q;
	logic [31:0] errEn_q;
	logic [31:0] statEn_q;
	logic [1:0] lineEn_q;
	logic absRun_q;
	logic absMode_q;
	logic [6:0] absCode_q;
	logic [13:0] absOffset_q;
	logic relRun_q;
	logic relMode_q;
	logic [13:0] relCount_q;
	logic [13:0] relElapsed_q;
	logic [1:0] tFlag_q;
	logic tint0_q;
	logic tint1_q;
	logic irq0_q;
	logic irq1_q;

	logic busReq;
	logic accept;
	logic wrAcc;
	logic [31:0] wrMask;
	logic [31:0] wrBits;
	logic [7:0] byteAddr;
	logic absFire;
	logic relFire;
	logic [31:0] statusAll;
	logic [31:0] errPend;
	logic [31:0] statPend;
	logic irq0_d;
	logic irq1_d;

	// Byte lanes to a bit mask; used by the line-select and enable registers only
	function automatic logic [31:0] laneMask(input logic [3:0] be);
		logic [31:0] m;
		m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
		return m;
	endfunction

	// Cycle filter: highest set code bit picks the repetition, bits below it the base cycle
	function automatic logic cycleHit(input logic [6:0] code, input logic [5:0] cyc);
		logic [6:0] m;
		m = 7'h00;
		for (int i = 0; i < 7; i++) begin
			if (code[i]) begin
				m = 7'((7'h01 << i) - 7'h01);
			end
		end
		return (code != 7'h00) && ((({1'b0, cyc} ^ code) & m) == 7'h00);
	endfunction

	assign byteAddr = {avs_address, 2'b00};
	assign busReq = avs_read | avs_write;
	assign accept = busReq & ~waitReq_q;
	assign wrAcc = avs_write & ~waitReq_q;
	assign wrMask = laneMask(avs_byteenable);
	assign wrBits = avs_writedata & wrMask;

	// One wait state gives decode a full cycle at 250 MHz
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			waitReq_q <= 1'b1;
		end else begin
			waitReq_q <= ~(busReq & waitReq_q);
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rdData_q <= 32'h0000_0000;
		end else if (avs_read & waitReq_q) begin
			unique case (byteAddr)
				irqmt_pkg::ERR_LINE_SEL_OFS: rdData_q <= errLineSel_q;
				irqmt_pkg::STAT_LINE_SEL_OFS: rdData_q <= statLineSel_q;
				irqmt_pkg::ERR_EN_SET_OFS, irqmt_pkg::ERR_EN_CLR_OFS: rdData_q <= errEn_q;
				irqmt_pkg::STAT_EN_SET_OFS, irqmt_pkg::STAT_EN_CLR_OFS: rdData_q <= statEn_q;
				irqmt_pkg::LINE_EN_OFS: rdData_q <= {30'h0, lineEn_q};
				irqmt_pkg::ABS_TIMER_OFS: rdData_q <= {2'h0, absOffset_q, 1'b0, absCode_q,
					6'h00, absMode_q, absRun_q};
				irqmt_pkg::REL_TIMER_OFS: rdData_q <= {2'h0, relCount_q, 14'h0000,
					relMode_q, relRun_q};
				irqmt_pkg::TIMER_FLAG_OFS: rdData_q <= {30'h0, tFlag_q};
				default: rdData_q <= 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			errLineSel_q <= irqmt_pkg::ERR_SEL_RESET;
			statLineSel_q <= irqmt_pkg::STAT_SEL_RESET;
			lineEn_q <= irqmt_pkg::LINE_EN_RESET;
		end else if (wrAcc) begin
			if (byteAddr == irqmt_pkg::ERR_LINE_SEL_OFS) begin
				errLineSel_q <= ((errLineSel_q & ~wrMask) | wrBits) & irqmt_pkg::ERR_MASK;
			end
			if (byteAddr == irqmt_pkg::STAT_LINE_SEL_OFS) begin
				statLineSel_q <= ((statLineSel_q & ~wrMask) | wrBits) & irqmt_pkg::STAT_MASK;
			end
			if (byteAddr == irqmt_pkg::LINE_EN_OFS && avs_byteenable[0]) begin
				lineEn_q <= avs_writedata[1:0];
			end
		end
	end

	// Enable pairs: zeros written leave bits alone, so no read-modify-write race
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			errEn_q <= irqmt_pkg::EN_RESET;
		end else if (wrAcc && byteAddr == irqmt_pkg::ERR_EN_SET_OFS) begin
			errEn_q <= errEn_q | (wrBits & irqmt_pkg::ERR_MASK);
		end else if (wrAcc && byteAddr == irqmt_pkg::ERR_EN_CLR_OFS) begin
			errEn_q <= errEn_q & ~wrBits;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			statEn_q <= irqmt_pkg::EN_RESET;
		end else if (wrAcc && byteAddr == irqmt_pkg::STAT_EN_SET_OFS) begin
			statEn_q <= statEn_q | (wrBits & irqmt_pkg::STAT_MASK);
		end else if (wrAcc && byteAddr == irqmt_pkg::STAT_EN_CLR_OFS) begin
			statEn_q <= statEn_q & ~wrBits;
		end
	end

	// Absolute timer: no counter of its own, compares the shared macrotick
	assign absFire = absRun_q & pocNormal & mtTick & (macrotick == absOffset_q)
		& cycleHit(absCode_q, cycleCount);

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			absRun_q <= 1'b0;
			absMode_q <= 1'b0;
			absCode_q <= 7'h00;
			absOffset_q <= 14'h0000;
		end else if (wrAcc && byteAddr == irqmt_pkg::ABS_TIMER_OFS) begin
			absRun_q <= avs_writedata[irqmt_pkg::RUN_BIT];
			absMode_q <= avs_writedata[irqmt_pkg::MODE_BIT];
			absCode_q <= avs_writedata[irqmt_pkg::CODE_LSB +: irqmt_pkg::CODE_W];
			absOffset_q <= avs_writedata[irqmt_pkg::MT_LSB +: irqmt_pkg::MT_W];
		end else if (!pocNormal) begin
			absRun_q <= 1'b0;
		end else if (absFire && !absMode_q) begin
			absRun_q <= 1'b0;
		end
	end

	// Relative timer counts macroticks since arming or since its last expiry
	assign relFire = relRun_q & pocNormal & mtTick
		& (14'(relElapsed_q + 14'h0001) == relCount_q);

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			relRun_q <= 1'b0;
			relMode_q <= 1'b0;
			relCount_q <= 14'h0000;
		end else if (wrAcc && byteAddr == irqmt_pkg::REL_TIMER_OFS) begin
			relRun_q <= avs_writedata[irqmt_pkg::RUN_BIT];
			relMode_q <= avs_writedata[irqmt_pkg::MODE_BIT];
			relCount_q <= avs_writedata[irqmt_pkg::MT_LSB +: irqmt_pkg::MT_W];
		end else if (!pocNormal) begin
			relRun_q <= 1'b0;
		end else if (relFire && !relMode_q) begin
			relRun_q <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			relElapsed_q <= 14'h0000;
		end else if (!relRun_q || !pocNormal || relFire) begin
			relElapsed_q <= 14'h0000;
		end else if (mtTick) begin
			relElapsed_q <= 14'(relElapsed_q + 14'h0001);
		end
	end

	// Outputs last until the next macrotick, or drop at once on halt or state exit
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			tint0_q <= 1'b0;
		end else if (absFire) begin
			tint0_q <= 1'b1;
		end else if (mtTick || !pocNormal
			|| (wrAcc && byteAddr == irqmt_pkg::ABS_TIMER_OFS && !avs_writedata[0])) begin
			tint0_q <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			tint1_q <= 1'b0;
		end else if (relFire) begin
			tint1_q <= 1'b1;
		end else if (mtTick || !pocNormal
			|| (wrAcc && byteAddr == irqmt_pkg::REL_TIMER_OFS && !avs_writedata[0])) begin
			tint1_q <= 1'b0;
		end
	end

	// Timer flags clear by writing 1; a fire in the same cycle wins
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			tFlag_q <= 2'h0;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if ((i == 0) ? absFire : relFire) begin
					tFlag_q[i] <= 1'b1;
				end else if (wrAcc && byteAddr == irqmt_pkg::TIMER_FLAG_OFS
					&& avs_writedata[i]) begin
					tFlag_q[i] <= 1'b0;
				end
			end
		end
	end

	always_comb begin
		statusAll = statusFlagReg;
		statusAll[irqmt_pkg::TIMER_ZERO_BIT] = tFlag_q[0];
		statusAll[irqmt_pkg::TIMER_ONE_BIT] = tFlag_q[1];
	end

	assign errPend = errorFlagReg & errEn_q & irqmt_pkg::ERR_MASK;
	assign statPend = statusAll & statEn_q & irqmt_pkg::STAT_MASK;
	assign irq0_d = lineEn_q[0]
		& (|(errPend & ~errLineSel_q) | |(statPend & ~statLineSel_q));
	assign irq1_d = lineEn_q[1]
		& (|(errPend & errLineSel_q) | |(statPend & statLineSel_q));

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			irq0_q <= 1'b0;
			irq1_q <= 1'b0;
		end else begin
			irq0_q <= irq0_d;
			irq1_q <= irq1_d;
		end
	end

	assign avs_readdata = rdData_q;
	assign avs_waitrequest = waitReq_q;
	assign hostIrqLineZero = irq0_q;
	assign hostIrqLineOne = irq1_q;
	assign timerZeroOut = tint0_q;
	assign timerOneOut = tint1_q;
	assign timerFlags = tFlag_q;

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	statusRoute_a: assert property (
		(|(statusAll & statEn_q & irqmt_pkg::STAT_MASK & statLineSel_q) && lineEn_q[1])
		|=> hostIrqLineOne)
		else $error("Selected status flag did not raise line one");

	errorRoute_a: assert property (
		(|(errorFlagReg & errEn_q & irqmt_pkg::ERR_MASK & ~errLineSel_q) && lineEn_q[0])
		|=> hostIrqLineZero)
		else $error("Error flag on line zero did not raise it");

	errEnPair_a: assert property (
		(wrAcc && byteAddr == irqmt_pkg::ERR_EN_CLR_OFS)
		|=> ((errEn_q & $past(wrBits)) == 32'h0000_0000))
		else $error("Error enable clear left a bit set");

	statEnSet_a: assert property (
		(wrAcc && byteAddr == irqmt_pkg::STAT_EN_SET_OFS)
		|=> ((statEn_q & $past(wrBits) & irqmt_pkg::STAT_MASK)
			== ($past(wrBits) & irqmt_pkg::STAT_MASK)))
		else $error("Status enable set missed a bit");

	lineGate_a: assert property (
		(!lineEn_q[0] && !lineEn_q[1]) |=> (!hostIrqLineZero && !hostIrqLineOne))
		else $error("Interrupt line high while disabled");

	noPending_a: assert property (
		(errPend == 32'h0000_0000 && statPend == 32'h0000_0000) |=> !hostIrqLineOne)
		else $error("Line one high with nothing pending");

	absPulse_a: assert property (
		absFire |=> (timerZeroOut && timerFlags[0]))
		else $error("Absolute timer pulse or flag missing");

	absHold_a: assert property (
		(timerZeroOut && !mtTick && pocNormal
			&& !(wrAcc && byteAddr == irqmt_pkg::ABS_TIMER_OFS))
		|=> timerZeroOut)
		else $error("Timer-zero pulse ended before the next macrotick");

	absExit_a: assert property (
		(!pocNormal && !absFire) |=> !timerZeroOut)
		else $error("Timer-zero output held after leaving normal states");

	relFire_a: assert property (
		(relRun_q && pocNormal && mtTick && relElapsed_q == 14'(relCount_q - 14'h0001))
		|=> (timerOneOut && timerFlags[1]))
		else $error("Relative timer did not fire at its count");

	singleShot_a: assert property (
		(absFire && !absMode_q && !wrAcc) |=> !absRun_q)
		else $error("Single-shot absolute timer kept running");

	stateStop_a: assert property (
		(!pocNormal && !wrAcc) |=> (!absRun_q && !relRun_q))
		else $error("Timer still armed outside normal states");

	busAnswer_a: assert property (
		(busReq && avs_waitrequest) |=> !avs_waitrequest)
		else $error("Bus request not answered after one wait state");

	absFireCov: cover property (absFire ##[1:1000] absFire);
	relFireCov: cover property (relFire && relMode_q ##[1:1000] relFire);
	bothLinesCov: cover property (hostIrqLineZero && hostIrqLineOne);
	flagClearCov: cover property (timerFlags[0] ##1 !timerFlags[0]);
endmodule

// *** include/irqmt_pkg.sv ***
// Purpose: Constants for interrupt routing and macrotick timers
// Assumes: 32-bit Avalon-MM register window, byte addresses
// Notes: Widths fixed at the documented values
package irqmt_pkg;
	localparam logic [7:0] ERR_LINE_SEL_OFS = 8'h28;
	localparam logic [7:0] STAT_LINE_SEL_OFS = 8'h2c;
	localparam logic [7:0] ERR_EN_SET_OFS = 8'h30;
	localparam logic [7:0] ERR_EN_CLR_OFS = 8'h34;
	localparam logic [7:0] STAT_EN_SET_OFS = 8'h38;
	localparam logic [7:0] STAT_EN_CLR_OFS = 8'h3c;
	localparam logic [7:0] LINE_EN_OFS = 8'h40;
	localparam logic [7:0] ABS_TIMER_OFS = 8'h44;
	localparam logic [7:0] REL_TIMER_OFS = 8'h48;
	localparam logic [7:0] TIMER_FLAG_OFS = 8'h4c;

	localparam logic [31:0] ERR_MASK = 32'h0707_0fff;
	localparam logic [31:0] STAT_MASK = 32'h0303_ffff;
	localparam logic [31:0] ERR_SEL_RESET = 32'h0000_0000;
	localparam logic [31:0] STAT_SEL_RESET = 32'h0303_ffff;
	localparam logic [31:0] EN_RESET = 32'h0000_0000;
	localparam logic [1:0] LINE_EN_RESET = 2'h0;

	localparam int TIMER_ZERO_BIT = 8;
	localparam int TIMER_ONE_BIT = 9;

	// Timer config layout: run, mode, cycle code, macrotick field
	localparam int RUN_BIT = 0;
	localparam int MODE_BIT = 1;
	localparam int CODE_LSB = 8;
	localparam int CODE_W = 7;
	localparam int MT_LSB = 16;
	localparam int MT_W = 14;
	localparam int CYC_W = 6;
endpackage

// *** bench/irqmt_host.sv ***
// Purpose: Host side of the block, a bus master that programs and services it
// Assumes: Slave answers by dropping waitrequest; master waits as long as needed
// Notes: Timers are always halted before a new configuration is loaded
`timescale 1ns/1ps
module irqmt_host (
	input wire logic clk,
	output logic [5:0] avs_address,
	output logic avs_read,
	output logic avs_write,
	output logic [31:0] avs_writedata,
	output logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest
);
	initial begin
		avs_address = 6'h0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		avs_byteenable = 4'hf;
	end

	task automatic xfer(input logic wr, input logic [7:0] ofs, input logic [31:0] d,
		output logic [31:0] q);
		avs_address <= ofs[7:2];
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		// Released data must not look held
		avs_writedata <= ~d;
		@(posedge clk);
	endtask

	task automatic timer(input logic [7:0] ofs, input logic [31:0] cfg);
		logic [31:0] q;
		xfer(1'b1, ofs, 32'h0, q);
		xfer(1'b1, ofs, cfg & ~32'h1, q);
		xfer(1'b1, ofs, cfg, q);
	endtask
endmodule

// *** bench/irqmt_top_tb.sv ***
// Purpose: Self-checking bench for interrupt routing and macrotick timers
// Assumes: Macrotick wraps at 8 to keep cycles short
// Notes: Random values from a fixed seed
`timescale 1ns/1ps
module irqmt_top_tb;
	logic clk, sysRst, mtTick, pocNormal, zeroPrev, onePrev, avsRead, avsWrite, avsWaitrequest;
	logic hostIrqLineZero, hostIrqLineOne, timerZeroOut, timerOneOut;
	logic [1:0] timerFlags, le;
	logic [3:0] avsByteenable;
	logic [5:0] avsAddress, cycleCount, tickCyc;
	logic [13:0] macrotick, tickMt, absOfs;
	logic [31:0] errorFlagReg, statusFlagReg, avsWritedata, avsReaddata, q, a, b, c, m;
	logic [31:0] ee, se, es, ss;
	logic [7:0] so;
	int seed = 8;
	int failCount = 0, comparisons = 0, div = 0, ticks = 0, lastTicks = 0;
	int zeroRises = 0, oneRises = 0, relCount = 3;

	irqmt_top dut_u (.clk(clk), .sys_rst(sysRst), .avs_address(avsAddress),
		.avs_read(avsRead), .avs_write(avsWrite), .avs_writedata(avsWritedata),
		.avs_byteenable(avsByteenable), .avs_readdata(avsReaddata),
		.avs_waitrequest(avsWaitrequest), .errorFlagReg(errorFlagReg),
		.statusFlagReg(statusFlagReg), .mtTick(mtTick), .macrotick(macrotick),
		.cycleCount(cycleCount), .pocNormal(pocNormal), .hostIrqLineZero(hostIrqLineZero),
		.hostIrqLineOne(hostIrqLineOne), .timerZeroOut(timerZeroOut),
		.timerOneOut(timerOneOut), .timerFlags(timerFlags));
	irqmt_host hostU (.clk(clk), .avs_address(avsAddress), .avs_read(avsRead),
		.avs_write(avsWrite), .avs_writedata(avsWritedata), .avs_byteenable(avsByteenable),
		.avs_readdata(avsReaddata), .avs_waitrequest(avsWaitrequest));

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			failCount++;
			$display("unexpected %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic endOfTest();
		if (failCount == 0 && comparisons > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask

	function automatic logic expLine(input logic one, input logic [31:0] ef, input logic [31:0] sf);
		logic [31:0] re, rs;
		re = ef & ee & irqmt_pkg::ERR_MASK & (one ? es : ~es);
		rs = sf & se & irqmt_pkg::STAT_MASK & (one ? ss : ~ss);
		return le[one] & ((|re) | (|rs));
	endfunction

	// Free-running time base; macrotick shows its new value with the tick
	always @(posedge clk) begin
		div <= (div + 1) % 4;
		mtTick <= (div == 3);
		if (div == 3) begin
			macrotick <= (macrotick == 14'h7) ? 14'h0 : macrotick + 14'h1;
			if (macrotick == 14'h7) cycleCount <= cycleCount + 6'h1;
		end
	end

	always @(posedge clk) begin
		if (mtTick === 1'b1) begin
			tickMt = macrotick;
			tickCyc = cycleCount;
			ticks++;
		end
		if (timerZeroOut === 1'b1 && !zeroPrev) begin
			zeroRises++;
			check("abs offset", {18'h0, absOfs}, {18'h0, tickMt});
			check("abs cycle", 32'h0, {31'h0, tickCyc[0]});
		end
		if (timerOneOut === 1'b1 && !onePrev) begin
			if (oneRises > 0) check("rel spacing", relCount, ticks - lastTicks);
			lastTicks = ticks;
			oneRises++;
		end
		zeroPrev = (timerZeroOut === 1'b1);
		onePrev = (timerOneOut === 1'b1);
	end

	initial begin
		#80000;
		failCount++;
		endOfTest();
	end

	initial begin
		sysRst = 1'b1;
		mtTick = 1'b0;
		macrotick = 14'h0;
		cycleCount = 6'h0;
		pocNormal = 1'b1;
		errorFlagReg = 32'h0;
		statusFlagReg = 32'h0;
		absOfs = 14'h5;
		zeroPrev = 1'b0;
		onePrev = 1'b0;
		repeat (20) @(posedge clk);
		sysRst <= 1'b0;
		@(posedge clk);
		hostU.xfer(1'b0, irqmt_pkg::STAT_LINE_SEL_OFS, 32'h0, q);
		check("status select reset", irqmt_pkg::STAT_SEL_RESET, q);
		hostU.xfer(1'b0, irqmt_pkg::ERR_EN_SET_OFS, 32'h0, q);
		check("error enable reset", irqmt_pkg::EN_RESET, q);
		hostU.xfer(1'b0, 8'hfc, 32'h0, q);
		check("unmapped read", 32'h0, q);
		// Enable pairs: two sets accumulate, a clear removes only ones
		for (int i = 0; i < 16; i++) begin
			so = i[0] ? irqmt_pkg::STAT_EN_SET_OFS : irqmt_pkg::ERR_EN_SET_OFS;
			m = i[0] ? irqmt_pkg::STAT_MASK : irqmt_pkg::ERR_MASK;
			a = $random(seed);
			b = $random(seed);
			c = $random(seed);
			hostU.xfer(1'b1, so + 8'h4, 32'hffff_ffff, q);
			hostU.xfer(1'b1, so, a, q);
			hostU.xfer(1'b1, so, b, q);
			hostU.xfer(1'b0, so + 8'h4, 32'h0, q);
			check("enable set", (a | b) & m, q);
			hostU.xfer(1'b1, so + 8'h4, c, q);
			hostU.xfer(1'b0, so, 32'h0, q);
			check("enable clear", (a | b) & ~c & m, q);
		end
		for (int i = 0; i < 24; i++) begin
			ee = $random(seed);
			se = $random(seed);
			es = $random(seed);
			ss = $random(seed);
			le = 2'($random(seed));
			hostU.xfer(1'b1, irqmt_pkg::ERR_EN_CLR_OFS, ~ee, q);
			hostU.xfer(1'b1, irqmt_pkg::ERR_EN_SET_OFS, ee, q);
			hostU.xfer(1'b1, irqmt_pkg::STAT_EN_CLR_OFS, ~se, q);
			hostU.xfer(1'b1, irqmt_pkg::STAT_EN_SET_OFS, se, q);
			hostU.xfer(1'b1, irqmt_pkg::ERR_LINE_SEL_OFS, es, q);
			hostU.xfer(1'b1, irqmt_pkg::STAT_LINE_SEL_OFS, ss, q);
			hostU.xfer(1'b1, irqmt_pkg::LINE_EN_OFS, {30'h0, le}, q);
			// Sparse flags so that single routes decide the line
			errorFlagReg <= $random(seed) & $random(seed) & $random(seed);
			statusFlagReg <= $random(seed) & $random(seed) & ~32'h300;
			repeat (3) @(posedge clk);
			check("line zero", expLine(1'b0, errorFlagReg, statusFlagReg), hostIrqLineZero);
			check("line one", expLine(1'b1, errorFlagReg, statusFlagReg), hostIrqLineOne);
		end
		// Relative timer, continuous, count 3
		oneRises = 0;
		hostU.timer(irqmt_pkg::REL_TIMER_OFS, (32'(relCount) << 16) | 32'h3);
		repeat (160) @(posedge clk);
		check("rel fires", 32'h1, {31'h0, oneRises >= 12});
		check("rel flag", 32'h1, {31'h0, timerFlags[1]});
		hostU.xfer(1'b1, irqmt_pkg::REL_TIMER_OFS, 32'h0, q);
		repeat (8) @(posedge clk);
		oneRises = 0;
		hostU.timer(irqmt_pkg::REL_TIMER_OFS, 32'h0001_0001);
		repeat (80) @(posedge clk);
		check("rel single", 32'h1, oneRises);
		// Absolute timer, continuous, even cycles at offset 5
		zeroRises = 0;
		hostU.timer(irqmt_pkg::ABS_TIMER_OFS, 32'h0005_0203);
		repeat (160) @(posedge clk);
		check("abs fires", 32'h1, {31'h0, zeroRises >= 2});
		check("abs flag", 32'h1, {31'h0, timerFlags[0]});
		hostU.xfer(1'b1, irqmt_pkg::ABS_TIMER_OFS, 32'h0, q);
		repeat (8) @(posedge clk);
		zeroRises = 0;
		hostU.timer(irqmt_pkg::ABS_TIMER_OFS, 32'h0005_0201);
		repeat (160) @(posedge clk);
		check("abs single", 32'h1, zeroRises);
		hostU.xfer(1'b0, irqmt_pkg::TIMER_FLAG_OFS, 32'h0, q);
		check("timer flags", 32'h3, q);
		hostU.xfer(1'b1, irqmt_pkg::TIMER_FLAG_OFS, 32'h1, q);
		hostU.xfer(1'b0, irqmt_pkg::TIMER_FLAG_OFS, 32'h0, q);
		check("timer flag clear", 32'h2, q);
		// Leaving normal state while the pulse stands
		hostU.timer(irqmt_pkg::ABS_TIMER_OFS, 32'h0005_0203);
		for (int n = 0; n < 200 && timerZeroOut !== 1'b1; n++) @(posedge clk);
		check("abs armed pulse", 32'h1, {31'h0, timerZeroOut});
		pocNormal <= 1'b0;
		@(posedge clk);
		@(negedge clk);
		check("abs drop", 32'h0, {31'h0, timerZeroOut});
		@(posedge clk);
		hostU.xfer(1'b0, irqmt_pkg::ABS_TIMER_OFS, 32'h0, q);
		check("abs run off", 32'h0, {31'h0, q[0]});
		oneRises = 0;
		hostU.timer(irqmt_pkg::REL_TIMER_OFS, 32'h0001_0003);
		repeat (40) @(posedge clk);
		check("rel idle", 32'h0, oneRises);
		endOfTest();
	end
endmodule
